/* File: hdl/fis_pkg.sv */
package fis_pkg;
  // Register offsets on the device's internal register port
  localparam logic [7:0] CTRL_STAT_OFS = 8'h22;
  localparam logic [7:0] TEST_STAT_OFS = 8'h23;
  localparam logic [7:0] MON_STATE_OFS = 8'h30;
  // Reset values
  localparam logic [7:0] CTRL_STAT_RST = 8'h00;
  localparam logic [7:0] TEST_STAT_RST = 8'h00;
  // Control/communication register bit positions
  localparam int CTRL_CRC_BIT = 4;
  localparam int CTRL_IRQ_BIT = 3;
  localparam int CTRL_TSD_BIT = 2;
  localparam int CTRL_PEC_BIT = 0;
  // Test/configuration-load register bit positions
  localparam int TEST_SEC_BIT = 3;
  localparam int TEST_DED_BIT = 2;
  localparam int TEST_DONE_BIT = 1;
  localparam int TEST_FAIL_BIT = 0;
  // Monitor state status bit
  localparam int MON_FAILSAFE_BIT = 7;
  // Implemented bits, reserved bits read zero
  localparam logic [7:0] CTRL_IMPL_MASK = 8'h1d;
  localparam logic [7:0] TEST_IMPL_MASK = 8'h0f;
endpackage

/* File: hdl/fis_flag_bit.sv */
`timescale 1ns/100ps
`default_nettype none
// One sticky write-one-to-clear flag; set wins over clear
module fis_flag_bit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Event side
  input wire logic setEvt,
  input wire logic condActive,
  input wire logic condGated,
  // Host side
  input wire logic clrReq,
  // Flag
  output logic flag
);
  logic flag_r;
  logic flag_nxt;

  // Gated flags refuse the clear while the condition still holds
  always_comb begin
    flag_nxt = flag_r;
    if (clrReq && !(condGated && condActive)) begin
      flag_nxt = 1'b0;
    end
    if (setEvt) begin
      flag_nxt = 1'b1;
    end
  end

  // Synchronous reset to zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;
endmodule
`default_nettype wire

/* File: hdl/fault_interrupt_status.sv */
`timescale 1ns/100ps
`default_nettype none
// Function
// R1 - Control/communication status at 22h resets to all zeros.
// R2 - Test/configuration-load status at 23h resets to all zeros.
// R3 - Flags stay latched after recovery; only host write-one clears them.
// R4 - Bit 4 sets on runtime register check mismatch while its enable is set.
// R5 - Register check flag clears unconditionally; sets again on mismatch.
// R6 - Bit 3 sets on interrupt pin fault; always enabled.
// R7 - Interrupt pin fault flag clears only once the pin fault is gone.
// R8 - Bit 2 sets on thermal shutdown when enabled; clears only once gone.
// R9 - Bit 0 sets on packet check mismatch or missing required check byte.
// R10 - Packet check flag clears unconditionally; sets again on repeat fault.
// R11 - Test bit 3 sets on corrected single ECC error when enabled.
// R12 - Test bit 2 sets on double ECC error, no enable; enters failsafe.
// R13 - Test bit 1 sets on self-test completion when enabled.
// R14 - Test bit 0 sets on self-test failure when enabled.
// R15 - Failsafe state reads as one in bit 7 of status at 30h.
// R16 - Reserved bits read zero and ignore writes.
module fault_interrupt_status (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Internal register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // Enables from control_fault_enables and test_fault_enables
  input wire logic runtimeRegisterCheckEnable,
  input wire logic thermalShutdownEnable,
  input wire logic packetCheckEnable,
  input wire logic singleErrorEnable,
  input wire logic selfTestDoneEnable,
  input wire logic selfTestFailEnable,
  // Misc monitor config
  input wire logic requirePacketCheck,
  // Fault events and conditions
  input wire logic regCheckDone,
  input wire logic regCheckMismatch,
  input wire logic interruptRequestPinFault,
  input wire logic thermalShutdown,
  input wire logic packetCheckMismatch,
  input wire logic writeMissingPacketCheck,
  input wire logic configLoadSingleError,
  input wire logic configLoadDoubleError,
  input wire logic selfTestDone,
  input wire logic selfTestFail,
  // Flags and failsafe
  output logic [7:0] controlCommFaultStatus,
  output logic [7:0] testLoadFaultStatus,
  output logic failsafe
);
  logic [7:0] ctrlFlags;
  logic [7:0] testFlags;
  logic [7:0] ctrlSet;
  logic [7:0] ctrlGate;
  logic [7:0] ctrlCond;
  logic [7:0] testSet;
  logic [7:0] ctrlClr;
  logic [7:0] testClr;
  logic ctrlWr;
  logic testWr;
  logic failsafe_r;
  logic failsafe_nxt;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic rdValid_r;
  logic rdValid_nxt;

  // Address decode for write-one-to-clear
  assign ctrlWr = regWrEn && (regAddr == fis_pkg::CTRL_STAT_OFS);
  assign testWr = regWrEn && (regAddr == fis_pkg::TEST_STAT_OFS);
  // Reserved bits masked so writes there do nothing
  assign ctrlClr = ctrlWr ? (regWrData & fis_pkg::CTRL_IMPL_MASK)
                          : 8'h00; // R16
  assign testClr = testWr ? (regWrData & fis_pkg::TEST_IMPL_MASK)
                          : 8'h00; // R16

  // Control/communication set terms, enables gate the event not the flag
  always_comb begin
    ctrlSet = 8'h00;
    ctrlGate = 8'h00;
    ctrlCond = 8'h00;
    ctrlSet[fis_pkg::CTRL_CRC_BIT] = regCheckDone && regCheckMismatch
      && runtimeRegisterCheckEnable; // R4 R5
    ctrlSet[fis_pkg::CTRL_IRQ_BIT] = interruptRequestPinFault; // R6
    ctrlSet[fis_pkg::CTRL_TSD_BIT] = thermalShutdown
      && thermalShutdownEnable; // R8
    ctrlSet[fis_pkg::CTRL_PEC_BIT] = packetCheckEnable
      && (packetCheckMismatch
      || (requirePacketCheck && writeMissingPacketCheck)); // R9 R10
    // Pin and thermal flags hold while the fault persists
    ctrlGate[fis_pkg::CTRL_IRQ_BIT] = 1'b1; // R7
    ctrlGate[fis_pkg::CTRL_TSD_BIT] = 1'b1; // R8
    ctrlCond[fis_pkg::CTRL_IRQ_BIT] = interruptRequestPinFault; // R7
    ctrlCond[fis_pkg::CTRL_TSD_BIT] = thermalShutdown; // R8
  end

  // Test/configuration-load set terms
  always_comb begin
    testSet = 8'h00;
    testSet[fis_pkg::TEST_SEC_BIT] = configLoadSingleError
      && singleErrorEnable; // R11
    testSet[fis_pkg::TEST_DED_BIT] = configLoadDoubleError; // R12
    testSet[fis_pkg::TEST_DONE_BIT] = selfTestDone
      && selfTestDoneEnable; // R13
    testSet[fis_pkg::TEST_FAIL_BIT] = selfTestFail
      && selfTestFailEnable; // R14
  end

  // One sticky cell per implemented bit; reserved bits stay zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bits
      if (fis_pkg::CTRL_IMPL_MASK[gi]) begin : g_ctrl
        fis_flag_bit u_ctrl (
          .clk(clk),
          .rst_n(rst_n),
          .setEvt(ctrlSet[gi]),
          .condActive(ctrlCond[gi]),
          .condGated(ctrlGate[gi]),
          .clrReq(ctrlClr[gi]),
          .flag(ctrlFlags[gi])
        ); // R1 R3
      end else begin : g_ctrl_rsvd
        assign ctrlFlags[gi] = 1'b0; // R16
      end
      if (fis_pkg::TEST_IMPL_MASK[gi]) begin : g_test
        fis_flag_bit u_test (
          .clk(clk),
          .rst_n(rst_n),
          .setEvt(testSet[gi]),
          .condActive(1'b0),
          .condGated(1'b0),
          .clrReq(testClr[gi]),
          .flag(testFlags[gi])
        ); // R2 R3
      end else begin : g_test_rsvd
        assign testFlags[gi] = 1'b0; // R16
      end
    end
  endgenerate

  // Failsafe latches on double error; only reset leaves it
  always_comb begin
    failsafe_nxt = failsafe_r || configLoadDoubleError; // R12
  end

  // Read mux, registered one cycle after the strobe
  always_comb begin
    rdData_nxt = 8'h00;
    rdValid_nxt = regRdEn;
    if (regRdEn) begin
      case (regAddr)
        fis_pkg::CTRL_STAT_OFS: rdData_nxt = ctrlFlags;
        fis_pkg::TEST_STAT_OFS: rdData_nxt = testFlags;
        fis_pkg::MON_STATE_OFS: begin
          rdData_nxt[fis_pkg::MON_FAILSAFE_BIT] = failsafe_r; // R15
        end
        default: rdData_nxt = 8'h00;
      endcase
    end
  end

  // State and output registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      failsafe_r <= 1'b0;
      rdData_r <= 8'h00;
      rdValid_r <= 1'b0;
      controlCommFaultStatus <= fis_pkg::CTRL_STAT_RST; // R1
      testLoadFaultStatus <= fis_pkg::TEST_STAT_RST; // R2
    end else begin
      failsafe_r <= failsafe_nxt;
      rdData_r <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
      controlCommFaultStatus <= ctrlFlags;
      testLoadFaultStatus <= testFlags;
    end
  end

  assign regRdData = rdData_r;
  assign regRdValid = rdValid_r;
  assign failsafe = failsafe_r;
endmodule
`default_nettype wire

/* File: verification/fis_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// Flag timing seen only at the block's ports
module fis_checker (
  // Clock, reset and register port
  input wire logic clk,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  // Fault inputs and flag outputs
  input wire logic interruptRequestPinFault,
  input wire logic thermalShutdown,
  input wire logic thermalShutdownEnable,
  input wire logic configLoadDoubleError,
  input wire logic [7:0] controlCommFaultStatus,
  input wire logic [7:0] testLoadFaultStatus,
  input wire logic failsafe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Status copies trail an event by two edges
  pinSet_a: assert property (interruptRequestPinFault |-> ##2
    controlCommFaultStatus[3]) else $error("pin flag missing");
  thermSet_a: assert property (thermalShutdown && thermalShutdownEnable
    |-> ##2 controlCommFaultStatus[2]) else $error("thermal flag missing");
  dblErr_a: assert property (configLoadDoubleError |-> ##2
    testLoadFaultStatus[2] && failsafe) else $error("double error missed");
  // A pin flag may only fall after a clear taken with the pin healthy;
  // the fall that follows a mid-run reset is not a clear
  pinHold_a: assert property ($fell(controlCommFaultStatus[3])
    && $past(rst_n) |-> $past(
    regWrEn && regAddr == 8'h22 && regWrData[3] && !interruptRequestPinFault,
    2)) else $error("pin flag lost");
  safeHold_a: assert property (failsafe |=> failsafe)
    else $error("failsafe dropped");
  rsvdZero_a: assert property (!(controlCommFaultStatus & 8'he2)
    && !(testLoadFaultStatus & 8'hf0)) else $error("reserved bit set");
  // Read data equals what the status copy shows in the same cycle
  rdCtrl_a: assert property (regRdEn && regAddr == 8'h22 |=>
    regRdData == controlCommFaultStatus) else $error("22h read wrong");
  rdTest_a: assert property (regRdEn && regAddr == 8'h23 |=>
    regRdData == testLoadFaultStatus) else $error("23h read wrong");
  // Every read strobe, mapped or not, is answered one edge later
  rdValid_a: assert property (regRdEn |=> regRdValid)
    else $error("read valid missing");
endmodule
bind fault_interrupt_status fis_checker u_chk (.*);
`default_nettype wire

/* File: verification/fis_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Host side of the internal register port
module fis_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic regWrEn,
  output logic regRdEn,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  // Strobes idle from time zero
  initial {regWrEn, regRdEn, regAddr, regWrData} = 18'h00000;
  // Request held to the edge that takes it; stale data scrambled after
  task automatic acc(input logic wr, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    regWrEn <= wr;
    regRdEn <= !wr;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    {regWrEn, regRdEn} <= 2'b00;
    regWrData <= ~d;
    #1;
    q = regRdData;
  endtask
endmodule
`default_nettype wire

/* File: verification/test_fault_interrupt_status.sv */
`timescale 1ns/100ps
`default_nettype none
module test_fault_interrupt_status;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWrEn, regRdEn;
  logic [7:0] regAddr, regWrData, regRdData, a, d, q;
  logic [6:0] evt = 7'h00;
  logic [5:0] en = 6'h3f;
  logic [3:0] lv = 4'h0, op;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  // Steps op,addr,data: 0 reset, 1 levels, 2 pulse, 3 write, 4 read, 5 end
  logic [54:0][19:0] prog = {
    100'h42200_42300_50001_1073f_20000,
    100'h20100_4221d_322ff_20000_4221c,
    100'h1013f_322ef_42210_50002_10d00,
    100'h20000_20100_20200_20300_20500,
    100'h20600_42210_42300_1083f_20200,
    100'h42211_32211_42200_20100_42201,
    100'h322fe_42201_50003_20300_20500,
    100'h20600_4230b_3230b_42300_20300,
    100'h20500_20600_4230b_323ff_50004,
    100'h43000_20400_42304_43080_44000,
    100'h00000_43000_42300_42200_50005};
  fis_host_model h (.*);
  fault_interrupt_status u_dut (.*, .regRdValid(), .failsafe(),
    .controlCommFaultStatus(), .testLoadFaultStatus(),
    .runtimeRegisterCheckEnable(en[0]), .thermalShutdownEnable(en[1]),
    .packetCheckEnable(en[2]), .singleErrorEnable(en[3]),
    .selfTestDoneEnable(en[4]), .selfTestFailEnable(en[5]),
    .requirePacketCheck(lv[3]), .thermalShutdown(lv[2]),
    .interruptRequestPinFault(lv[1]), .regCheckMismatch(lv[0]),
    .regCheckDone(evt[0]), .packetCheckMismatch(evt[1]),
    .writeMissingPacketCheck(evt[2]), .configLoadSingleError(evt[3]),
    .configLoadDoubleError(evt[4]), .selfTestDone(evt[5]),
    .selfTestFail(evt[6]));
  // Free-running 100 MHz clock
  always #5 clk = ~clk;
  // A stalled handshake ends the run here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      final_report;
    end
  end
  // Verdict and the end of the run
  task automatic final_report;
    $display("Compared %0d, mismatched %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Steps start one edge apart, three after a write or read, so a pulse is seen exactly once
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 54; i >= 0; i--) begin
      {op, a, d} = prog[i];
      @(posedge clk);
      rst_n <= op != 4'h0;
      evt <= (op == 4'h2) ? 7'h01 << a[2:0] : 7'h00;
      if (op == 4'h1) {lv, en} <= {a[3:0], d[5:0]};
      if (op == 4'h5) $display("Test %0d done", d);
      if (op == 4'h3 || op == 4'h4) h.acc(op == 4'h3, a, d, q);
      if (op == 4'h4 && q !== d) begin
        $display("CHECK FAILED %0t read %h got %h want %h", $time, a, q, d);
        num_errors++;
      end
      if (op == 4'h4) samples_checked++;
    end
    final_report;
  end
endmodule
`default_nettype wire
